// >>> core/pox_pkg.sv
`default_nettype none
package pox_pkg;
    localparam int AXI_AW = 8;
    localparam int AXI_DW = 32;
    localparam int AXI_SW = 4;
    localparam int NUM_CORES = 2;
    localparam int FLASH_W = 6;
    localparam int LOW_W = 30;

    // register byte offsets
    localparam logic [7:0] LOW_OE_OFS = 8'h20;
    localparam logic [7:0] LOW_OE_SET_OFS = 8'h24;
    localparam logic [7:0] LOW_OE_CLR_OFS = 8'h28;
    localparam logic [7:0] LOW_OE_XOR_OFS = 8'h2c;
    localparam logic [7:0] FLASH_LVL_OFS = 8'h30;
    localparam logic [7:0] FLASH_LVL_SET_OFS = 8'h34;
    localparam logic [7:0] FLASH_LVL_CLR_OFS = 8'h38;
    localparam logic [7:0] FLASH_LVL_XOR_OFS = 8'h3c;
    localparam logic [7:0] FLASH_OE_OFS = 8'h40;
    localparam logic [7:0] FLASH_OE_SET_OFS = 8'h44;
    localparam logic [7:0] FLASH_OE_CLR_OFS = 8'h48;
    localparam logic [7:0] FLASH_OE_XOR_OFS = 8'h4c;

    // distance from a plain register to its aliases
    localparam logic [7:0] ALIAS_SET = 8'h04;
    localparam logic [7:0] ALIAS_CLR = 8'h08;
    localparam logic [7:0] ALIAS_XOR = 8'h0c;

    localparam logic [5:0] FLASH_LVL_RST = 6'h00;
    localparam logic [5:0] FLASH_OE_RST = 6'h00;
    localparam logic [29:0] LOW_OE_RST = 30'h0000000;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic awvalid;
        logic [AXI_AW-1:0] awaddr;
        logic wvalid;
        logic [AXI_DW-1:0] wdata;
        logic [AXI_SW-1:0] wstrb;
        logic bready;
        logic arvalid;
        logic [AXI_AW-1:0] araddr;
        logic rready;
    } pox_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [AXI_DW-1:0] rdata;
        logic [1:0] rresp;
    } pox_axi_rsp_t;
endpackage : pox_pkg
`default_nettype wire

// >>> core/pox_pin_regs.sv
`default_nettype none
// Functional notes
// - low-bank enable clear alias clears ones
// - low-bank enable toggle alias inverts ones
// - six-bit flash level register, resets zero
// - level readback is stored value, not pins
// - same-cycle writes: core 0 then core 1
// - flash level set alias ORs bits
// - flash level clear alias clears ones
// - flash level toggle alias inverts ones
// - six-bit flash enable register, resets zero
// - enable readback returns stored value
// - flash enable set alias ORs bits
// - flash enable clear alias clears ones
// - flash enable toggle alias inverts ones
// - thirty-bit low-bank enable register kept
module pox_pin_regs (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic ce,
    input wire pox_pkg::pox_axi_req_t core_req [pox_pkg::NUM_CORES],
    output var pox_pkg::pox_axi_rsp_t core_rsp [pox_pkg::NUM_CORES],
    output logic [pox_pkg::FLASH_W-1:0] flash_pin_level,
    output logic [pox_pkg::FLASH_W-1:0] flash_pin_drive_enable,
    output logic [pox_pkg::LOW_W-1:0] low_bank_enable
);
    localparam int NC = pox_pkg::NUM_CORES;

    logic rst_meta_reg;
    logic rst_sync_reg;
    wire logic rst_n = rst_sync_reg;

    logic [pox_pkg::FLASH_W-1:0] flash_lvl_reg;
    logic [pox_pkg::FLASH_W-1:0] flash_lvl_next;
    logic [pox_pkg::FLASH_W-1:0] flash_oe_reg;
    logic [pox_pkg::FLASH_W-1:0] flash_oe_next;
    logic [pox_pkg::LOW_W-1:0] low_oe_reg;
    logic [pox_pkg::LOW_W-1:0] low_oe_next;

    // per-core write holding state
    logic aw_held_reg [NC];
    logic w_held_reg [NC];
    logic [7:0] aw_addr_reg [NC];
    logic [31:0] w_data_reg [NC];
    logic [3:0] w_strb_reg [NC];
    logic commit [NC];
    logic wr_en [NC];

    // per-core bus handshake state; the port struct is only wiring
    logic awready_reg [NC];
    logic wready_reg [NC];
    logic bvalid_reg [NC];
    logic [1:0] bresp_reg [NC];
    logic arready_reg [NC];
    logic rvalid_reg [NC];
    logic [31:0] rdata_reg [NC];
    logic [1:0] rresp_reg [NC];
    logic aw_take [NC];
    logic w_take [NC];
    logic ar_take [NC];

    // only the word part of the address selects a register
    function automatic logic [7:0] word_addr(input logic [7:0] a);
        word_addr = {a[7:2], 2'b00};
    endfunction : word_addr

    function automatic logic is_mapped(input logic [7:0] a);
        logic [7:0] w;
        w = word_addr(a);
        is_mapped = (w >= pox_pkg::LOW_OE_OFS)
            && (w <= pox_pkg::FLASH_OE_XOR_OFS);
    endfunction : is_mapped

    // plain write merges by byte lane, aliases act on masked data
    function automatic logic [31:0] alias_update(
        input logic [31:0] cur,
        input logic [7:0] base,
        input logic [7:0] a,
        input logic [31:0] data,
        input logic [3:0] strb
    );
        logic [31:0] mask;
        logic [31:0] d;
        logic [7:0] w;
        mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        d = data & mask;
        w = word_addr(a);
        alias_update = cur;
        if (w == base) begin
            alias_update = (cur & ~mask) | d;
        end else if (w == base + pox_pkg::ALIAS_SET) begin
            alias_update = cur | d;
        end else if (w == base + pox_pkg::ALIAS_CLR) begin
            alias_update = cur & ~d;
        end else if (w == base + pox_pkg::ALIAS_XOR) begin
            alias_update = cur ^ d;
        end
    endfunction : alias_update

    function automatic logic [31:0] read_word(
        input logic [7:0] a,
        input logic [5:0] lvl,
        input logic [5:0] oe,
        input logic [29:0] low
    );
        logic [7:0] w;
        w = word_addr(a);
        read_word = 32'h00000000;
        if (w == pox_pkg::LOW_OE_OFS) begin
            read_word = {2'h0, low};
        end else if (w == pox_pkg::FLASH_LVL_OFS) begin
            read_word = {26'h0000000, lvl};
        end else if (w == pox_pkg::FLASH_OE_OFS) begin
            read_word = {26'h0000000, oe};
        end
    endfunction : read_word

    // reset release is synchronised, assertion stays asynchronous
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    genvar gc;
    generate
        for (gc = 0; gc < NC; gc++) begin : g_core
            // a write lands once address and data are both in and the
            // previous response has been taken
            assign commit[gc] = aw_held_reg[gc] && w_held_reg[gc]
                && !bvalid_reg[gc];
            assign wr_en[gc] = commit[gc] && is_mapped(aw_addr_reg[gc]);
            // each take is true whenever valid meets ready; only an edge with ce high moves the item
            assign aw_take[gc] = core_req[gc].awvalid && awready_reg[gc];
            assign w_take[gc] = core_req[gc].wvalid && wready_reg[gc];
            assign ar_take[gc] = core_req[gc].arvalid && arready_reg[gc];

            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    aw_held_reg[gc] <= 1'b0;
                end else if (ce) begin
                    if (commit[gc]) begin
                        aw_held_reg[gc] <= 1'b0;
                    end else if (aw_take[gc]) begin
                        aw_held_reg[gc] <= 1'b1;
                    end
                end
            end

            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    aw_addr_reg[gc] <= 8'h00;
                end else if (ce && aw_take[gc]) begin
                    aw_addr_reg[gc] <= core_req[gc].awaddr;
                end
            end

            // ready stays low from take to commit: one write in flight
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    awready_reg[gc] <= 1'b0;
                end else if (ce) begin
                    if (commit[gc]) begin
                        awready_reg[gc] <= 1'b1;
                    end else if (aw_take[gc]) begin
                        awready_reg[gc] <= 1'b0;
                    end else if (!aw_held_reg[gc]) begin
                        awready_reg[gc] <= 1'b1;
                    end
                end
            end

            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    w_held_reg[gc] <= 1'b0;
                end else if (ce) begin
                    if (commit[gc]) begin
                        w_held_reg[gc] <= 1'b0;
                    end else if (w_take[gc]) begin
                        w_held_reg[gc] <= 1'b1;
                    end
                end
            end

            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    w_data_reg[gc] <= 32'h00000000;
                    w_strb_reg[gc] <= 4'h0;
                end else if (ce && w_take[gc]) begin
                    w_data_reg[gc] <= core_req[gc].wdata;
                    w_strb_reg[gc] <= core_req[gc].wstrb;
                end
            end

            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    wready_reg[gc] <= 1'b0;
                end else if (ce) begin
                    if (commit[gc]) begin
                        wready_reg[gc] <= 1'b1;
                    end else if (w_take[gc]) begin
                        wready_reg[gc] <= 1'b0;
                    end else if (!w_held_reg[gc]) begin
                        wready_reg[gc] <= 1'b1;
                    end
                end
            end

            // response rises at the same edge that updates the register
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    bvalid_reg[gc] <= 1'b0;
                end else if (ce) begin
                    if (commit[gc]) begin
                        bvalid_reg[gc] <= 1'b1;
                    end else if (core_req[gc].bready) begin
                        bvalid_reg[gc] <= 1'b0;
                    end
                end
            end

            // refused writes answer with an error and store nothing
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    bresp_reg[gc] <= pox_pkg::RESP_OKAY;
                end else if (ce && commit[gc]) begin
                    bresp_reg[gc] <= is_mapped(aw_addr_reg[gc])
                        ? pox_pkg::RESP_OKAY : pox_pkg::RESP_SLVERR;
                end
            end

            // reads answer one cycle after the address is taken
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    arready_reg[gc] <= 1'b0;
                end else if (ce) begin
                    if (ar_take[gc]) begin
                        arready_reg[gc] <= 1'b0;
                    end else if (!rvalid_reg[gc] || core_req[gc].rready) begin
                        arready_reg[gc] <= 1'b1;
                    end
                end
            end

            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    rvalid_reg[gc] <= 1'b0;
                end else if (ce) begin
                    if (ar_take[gc]) begin
                        rvalid_reg[gc] <= 1'b1;
                    end else if (core_req[gc].rready) begin
                        rvalid_reg[gc] <= 1'b0;
                    end
                end
            end

            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    rdata_reg[gc] <= 32'h00000000;
                    rresp_reg[gc] <= pox_pkg::RESP_OKAY;
                end else if (ce && ar_take[gc]) begin
                    rdata_reg[gc] <= read_word(core_req[gc].araddr,
                        flash_lvl_reg, flash_oe_reg, low_oe_reg);
                    rresp_reg[gc] <= is_mapped(core_req[gc].araddr)
                        ? pox_pkg::RESP_OKAY : pox_pkg::RESP_SLVERR;
                end
            end

            // the port is plain wiring, every field comes from a flop
            assign core_rsp[gc] = '{
                awready: awready_reg[gc],
                wready: wready_reg[gc],
                bvalid: bvalid_reg[gc],
                bresp: bresp_reg[gc],
                arready: arready_reg[gc],
                rvalid: rvalid_reg[gc],
                rdata: rdata_reg[gc],
                rresp: rresp_reg[gc]
            };
        end
    endgenerate

    // core 0 is applied first, core 1 acts on the intermediate result
    always_comb begin
        logic [31:0] lvl_v;
        logic [31:0] oe_v;
        logic [31:0] low_v;
        lvl_v = {26'h0000000, flash_lvl_reg};
        oe_v = {26'h0000000, flash_oe_reg};
        low_v = {2'h0, low_oe_reg};
        for (int c = 0; c < NC; c++) begin
            if (wr_en[c]) begin
                lvl_v = alias_update(lvl_v, pox_pkg::FLASH_LVL_OFS,
                    aw_addr_reg[c], w_data_reg[c], w_strb_reg[c]);
                oe_v = alias_update(oe_v, pox_pkg::FLASH_OE_OFS,
                    aw_addr_reg[c], w_data_reg[c], w_strb_reg[c]);
                low_v = alias_update(low_v, pox_pkg::LOW_OE_OFS,
                    aw_addr_reg[c], w_data_reg[c], w_strb_reg[c]);
            end
        end
        // upper bits are dropped so reserved bits never store
        flash_lvl_next = lvl_v[pox_pkg::FLASH_W-1:0];
        flash_oe_next = oe_v[pox_pkg::FLASH_W-1:0];
        low_oe_next = low_v[pox_pkg::LOW_W-1:0];
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            flash_lvl_reg <= pox_pkg::FLASH_LVL_RST;
        end else if (ce) begin
            flash_lvl_reg <= flash_lvl_next;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            flash_oe_reg <= pox_pkg::FLASH_OE_RST;
        end else if (ce) begin
            flash_oe_reg <= flash_oe_next;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            low_oe_reg <= pox_pkg::LOW_OE_RST;
        end else if (ce) begin
            low_oe_reg <= low_oe_next;
        end
    end

    // pad drives come straight from the stored registers
    assign flash_pin_level = flash_lvl_reg;
    assign flash_pin_drive_enable = flash_oe_reg;
    assign low_bank_enable = low_oe_reg;
endmodule : pox_pin_regs
`default_nettype wire

// >>> core/unused_placeholder_none.sv
`default_nettype none
`default_nettype wire

// >>> test/pox_pin_regs_monitor.sv
`default_nettype none
module pox_pin_regs_monitor (
    input wire logic clock,
    input wire logic arst_n,
    input wire pox_pkg::pox_axi_req_t core_req [pox_pkg::NUM_CORES],
    input wire pox_pkg::pox_axi_rsp_t core_rsp [pox_pkg::NUM_CORES],
    input wire logic [5:0] flash_pin_level,
    input wire logic [5:0] flash_pin_drive_enable,
    input wire logic [29:0] low_bank_enable
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] bv_q;
    logic quiet;
    logic rd0;
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            bv_q <= 2'h0;
        end else begin
            bv_q <= {core_rsp[1].bvalid, core_rsp[0].bvalid};
        end
    end
    // pins may only move on the edge that raises a write response
    assign quiet = !(core_rsp[0].bvalid && !bv_q[0])
        && !(core_rsp[1].bvalid && !bv_q[1]);
    assign rd0 = core_req[0].arvalid && core_rsp[0].arready;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);
    AST_LVL_HOLD: assert property (
        quiet |-> $stable(flash_pin_level)) else $error("level moved");
    AST_OE_HOLD: assert property (
        quiet |-> $stable(flash_pin_drive_enable)) else $error("oe moved");
    AST_LOW_HOLD: assert property (
        quiet |-> $stable(low_bank_enable)) else $error("low oe moved");
    AST_LVL_READ: assert property (
        rd0 && core_req[0].araddr == pox_pkg::FLASH_LVL_OFS
        ##1 $stable(flash_pin_level)
        |-> core_rsp[0].rdata == {26'h0, flash_pin_level})
        else $error("level readback differs");
    AST_OE_READ: assert property (
        rd0 && core_req[0].araddr == pox_pkg::FLASH_OE_OFS
        ##1 $stable(flash_pin_drive_enable)
        |-> core_rsp[0].rdata == {26'h0, flash_pin_drive_enable})
        else $error("enable readback differs");
    AST_ALIAS_ZERO: assert property (
        rd0 && core_req[0].araddr[3:2] != 2'h0
        |=> core_rsp[0].rdata == 32'h0) else $error("alias read not zero");
    AST_READ_ANSWER: assert property (
        rd0 |=> core_rsp[0].rvalid) else $error("read answer late");
    AST_BAD_WRITE: assert property (
        core_req[0].awvalid && core_rsp[0].awready
        && core_req[0].wvalid && core_rsp[0].wready
        && !core_rsp[0].bvalid
        && (core_req[0].awaddr > 8'h4f || core_req[0].awaddr < 8'h20)
        |-> ##2 (core_rsp[0].bvalid
        && core_rsp[0].bresp == pox_pkg::RESP_SLVERR))
        else $error("unmapped write not refused");
endmodule : pox_pin_regs_monitor
`default_nettype wire

// >>> test/pox_core_model.sv
`default_nettype none
module pox_core_model (
    input wire logic clock,
    output var pox_pkg::pox_axi_req_t req,
    input wire pox_pkg::pox_axi_rsp_t rsp
);
    timeunit 1ns;
    timeprecision 1ns;
    initial req = '0;
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
            input logic [3:0] s, output logic [1:0] r);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge clock);
        req.awvalid <= 1'b1;
        req.awaddr <= a;
        req.wvalid <= 1'b1;
        req.wdata <= d;
        req.wstrb <= s;
        req.bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge clock);
            if (!aw_ok && rsp.awready) begin
                aw_ok = 1'b1;
                req.awvalid <= 1'b0;
                req.awaddr <= ~a;
            end
            if (!w_ok && rsp.wready) begin
                w_ok = 1'b1;
                req.wvalid <= 1'b0;
                req.wdata <= ~d;
            end
        end
        while (!rsp.bvalid) @(posedge clock);
        r = rsp.bresp;
        req.bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
            output logic [1:0] r);
        @(posedge clock);
        req.arvalid <= 1'b1;
        req.araddr <= a;
        req.rready <= 1'b1;
        do @(posedge clock); while (!rsp.arready);
        req.arvalid <= 1'b0;
        req.araddr <= ~a;
        while (!rsp.rvalid) @(posedge clock);
        d = rsp.rdata;
        r = rsp.rresp;
        req.rready <= 1'b0;
    endtask : rd
endmodule : pox_core_model
`default_nettype wire

// >>> test/tb_pox_pin_regs.sv
`default_nettype none
module tb_pox_pin_regs;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] data;
        logic [5:0] lvl;
        logic [5:0] oe;
        logic [29:0] low;
    } pox_row_t;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic ce = 1'b1;
    pox_pkg::pox_axi_req_t core_req [pox_pkg::NUM_CORES];
    pox_pkg::pox_axi_rsp_t core_rsp [pox_pkg::NUM_CORES];
    logic [5:0] lvl;
    logic [5:0] oe;
    logic [29:0] low;
    logic [31:0] d;
    logic [1:0] r0;
    logic [1:0] r1;
    int n_errors = 0;
    int n_compared = 0;
    int cycles = 0;
    // expected pins are cumulative: each row starts from the row above
    pox_row_t rows [11] = '{
        '{8'h30, 32'hffff_ffff, 6'h3f, 6'h00, 30'h0},
        '{8'h38, 32'h05, 6'h3a, 6'h00, 30'h0},
        '{8'h3c, 32'h0f, 6'h35, 6'h00, 30'h0},
        '{8'h34, 32'h02, 6'h37, 6'h00, 30'h0},
        '{8'h40, 32'h11, 6'h37, 6'h11, 30'h0},
        '{8'h44, 32'h06, 6'h37, 6'h17, 30'h0},
        '{8'h48, 32'h03, 6'h37, 6'h14, 30'h0},
        '{8'h4c, 32'h21, 6'h37, 6'h35, 30'h0},
        '{8'h20, 32'hffff_ffff, 6'h37, 6'h35, 30'h3fff_ffff},
        '{8'h28, 32'h0000_ffff, 6'h37, 6'h35, 30'h3fff_0000},
        '{8'h2c, 32'h3000_00ff, 6'h37, 6'h35, 30'h0fff_00ff}};
    always #25 clock = ~clock;
    pox_pin_regs pox_pin_regs_inst (.clock(clock), .arst_n(arst_n), .ce(ce),
        .core_req(core_req), .core_rsp(core_rsp), .flash_pin_level(lvl),
        .flash_pin_drive_enable(oe), .low_bank_enable(low));
    pox_core_model c0 (.clock(clock), .req(core_req[0]), .rsp(core_rsp[0]));
    pox_core_model c1 (.clock(clock), .req(core_req[1]), .rsp(core_rsp[1]));
    task automatic chk(input string what, input logic [41:0] e,
            input logic [41:0] g);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask : chk
    task automatic rchk(input logic [7:0] a, input logic [31:0] e,
            input logic [1:0] er);
        c0.rd(a, d, r0);
        chk("read data", {10'h0, e}, {10'h0, d});
        chk("read resp", {40'h0, er}, {40'h0, r0});
    endtask : rchk
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : print_verdict
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_errors++;
            print_verdict();
        end
    end
    initial begin
        repeat (10) @(posedge clock);
        arst_n <= 1'b1;
        repeat (3) @(posedge clock);
        chk("pins after reset", 42'h0, {low, lvl, oe});
        rchk(pox_pkg::FLASH_OE_OFS, 32'h0, pox_pkg::RESP_OKAY);
        $display("reset test done");
        foreach (rows[i]) begin
            c0.wr(rows[i].addr, rows[i].data, 4'hf, r0);
            chk("bresp", 42'h0, {40'h0, r0});
            chk("pins", {rows[i].low, rows[i].lvl, rows[i].oe},
                {low, lvl, oe});
        end
        $display("table test done");
        // the reverse order of the two cores would leave 0x0f here
        fork
            c0.wr(pox_pkg::FLASH_LVL_OFS, 32'h0f, 4'hf, r0);
            c1.wr(pox_pkg::FLASH_LVL_XOR_OFS, 32'h03, 4'hf, r1);
        join
        chk("level both cores", 42'h0c, {36'h0, lvl});
        fork
            c0.wr(pox_pkg::FLASH_OE_CLR_OFS, 32'h3f, 4'hf, r0);
            c1.wr(pox_pkg::FLASH_OE_SET_OFS, 32'h01, 4'hf, r1);
        join
        chk("enable both cores", 42'h01, {36'h0, oe});
        c1.rd(pox_pkg::FLASH_OE_OFS, d, r1);
        chk("core 1 enable read", 42'h01, {10'h0, d});
        $display("two core test done");
        rchk(pox_pkg::FLASH_LVL_OFS, 32'h0c, pox_pkg::RESP_OKAY);
        rchk(pox_pkg::FLASH_LVL_XOR_OFS, 32'h0, pox_pkg::RESP_OKAY);
        rchk(pox_pkg::LOW_OE_OFS, 32'h0fff_00ff, pox_pkg::RESP_OKAY);
        rchk(8'h50, 32'h0, pox_pkg::RESP_SLVERR);
        c0.wr(8'h50, 32'h3f, 4'hf, r0);
        chk("bad write resp", 42'h2, {40'h0, r0});
        chk("pins kept", {30'h0fff_00ff, 12'h301}, {low, lvl, oe});
        $display("readback test done");
        // strobes keep the unselected bytes of a plain write
        c0.wr(pox_pkg::LOW_OE_OFS, 32'h1234_5678, 4'h5, r0);
        chk("strobed low bank", {30'h0f34_0078, 12'h301},
            {low, lvl, oe});
        $display("strobe test done");
        arst_n <= 1'b0;
        repeat (2) @(posedge clock);
        chk("pins in reset", 42'h0, {low, lvl, oe});
        arst_n <= 1'b1;
        repeat (3) @(posedge clock);
        rchk(pox_pkg::LOW_OE_OFS, 32'h0, pox_pkg::RESP_OKAY);
        $display("mid-run reset test done");
        // ce low between take and commit must hold the write back
        fork
            c0.wr(pox_pkg::FLASH_LVL_SET_OFS, 32'h30, 4'hf, r0);
            begin
                @(posedge clock iff (core_req[0].awvalid
                    && core_rsp[0].awready));
                ce <= 1'b0;
                repeat (4) @(posedge clock);
                chk("frozen level", 42'h0, {36'h0, lvl});
                ce <= 1'b1;
            end
        join
        chk("level after freeze", 42'h30, {36'h0, lvl});
        $display("clock enable test done");
        print_verdict();
    end
endmodule : tb_pox_pin_regs
bind pox_pin_regs pox_pin_regs_monitor pox_pin_regs_monitor_inst (
    .clock(clock), .arst_n(arst_n), .core_req(core_req),
    .core_rsp(core_rsp), .flash_pin_level(flash_pin_level),
    .flash_pin_drive_enable(flash_pin_drive_enable),
    .low_bank_enable(low_bank_enable));
`default_nettype wire
